// File: pkg/nand_seq_pkg.sv
// Constants, timings and types shared by the NAND program/erase sequencer
package nand_seq_pkg;
    localparam int IO_W = 16;
    localparam int PIN_W = 22;
    localparam logic [PIN_W-1:0] PIN_RST = 22'h260000;
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_RAND_IN = 8'h85;
    localparam logic [7:0] CMD_PROG_CONF = 8'h10;
    localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
    localparam logic [7:0] CMD_CB_READ = 8'h35;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [2:0] ADDR_LAST = 3'h3;
    localparam logic [2:0] ERASE_ADDR_LAST = 3'h1;
    localparam logic [11:0] PAGE_BYTES = 12'h840;
    localparam logic [11:0] PAGE_WORDS = 12'h420;
    localparam int PAGE_DEPTH = 1056;
    localparam logic [10:0] XFER_LAST = 11'h41f;
    localparam int BLOCK_LSB = 6;
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS = 300000;
    localparam int ERASE_TIME_NS = 2000000;
    localparam int READ_TIME_NS = 25000;
    localparam int CACHE_TRANSFER_BUSY_TIME_NS = PAGE_DEPTH * CLK_PERIOD_NS;
    localparam int PROG_CYCLES =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES =
        (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYCLES = READ_TIME_NS / CLK_PERIOD_NS;
    localparam int CACHE_TRANSFER_CYCLES =
        CACHE_TRANSFER_BUSY_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STUCK = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h08;
    localparam logic [7:0] REG_ADDR = 8'h0c;
    localparam logic [7:0] REG_BLOCK = 8'h10;
    localparam int CFG_X16 = 0;
    localparam int CFG_ERASE_FAIL = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam logic [15:0] STUCK_RESET = 16'h0000;
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_ADDR = 6'b000010,
        S_DATA = 6'b000100,
        S_RWAIT = 6'b001000,
        S_EADDR = 6'b010000,
        S_ECONF = 6'b100000
    } cmd_state_t;
    typedef enum logic [2:0] {
        X_IDLE = 3'b001,
        X_WAIT = 3'b010,
        X_COPY = 3'b100
    } xfer_state_t;
    typedef enum logic [2:0] {
        AK_PROG = 3'b001,
        AK_RAND = 3'b010,
        AK_READ = 3'b100
    } addr_kind_t;
endpackage

// File: verilog/nand_program_erase_sequencer.sv
// NAND program, cache program, copy-back, erase and status sequencer
//
// Functional notes
// - 80h, four addresses, data from column
// - Page holds 2112 bytes or 1056 words
// - 85h plus column moves load pointer
// - 10h starts autonomous program and verify
// - Completion on ready/busy and status bit 6
// - While busy only status and reset accepted
// - Verify flags only failed one-to-zero bits
// - Status mode holds until next valid command taken while ready, or reset
// - 35h read moves page into buffer
// - Optional readout, 85h destination, 10h programs
// - 15h transfers cache to data register
// - Later transfers wait for current programming
// - Bit 6 cache ready, bit 5 array idle
// - Bit 1 previous page, bit 0 current
// - 60h, two block addresses, then D0h
// - Erase uses block bits, ignores page
// - Erase starts at confirm strobe edge
// - Erasing accepts only status and reset
// - Status driven live while chip enable and read strobe low, write strobe high
// - Write protect low blocks program, erase
// - Status bit polarities as encoded
// - Reset command aborts and returns idle
`timescale 1ns/1ps
module nand_program_erase_sequencer #(
    parameter int prog_cycles = nand_seq_pkg::PROG_CYCLES,
    parameter int erase_cycles = nand_seq_pkg::ERASE_CYCLES,
    parameter int read_cycles = nand_seq_pkg::READ_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    input wire logic [nand_seq_pkg::IO_W-1:0] io_in,
    output logic [nand_seq_pkg::IO_W-1:0] io_out,
    output logic io_oe_n,
    input wire logic ready_busy_line_in,
    output logic ready_busy_line_out,
    output logic ready_busy_line_oe_n
);
    import nand_seq_pkg::*;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] filt;
    logic f_ce_n, f_cle, f_ale, f_we_n, f_re_n, f_wp_n;
    logic [IO_W-1:0] f_io;
    logic we_d, re_d;
    logic we_rise, re_rise, bus_sel;
    logic cmd_wr, addr_wr, data_wr;
    logic [7:0] cmd;
    cmd_state_t cstate;
    xfer_state_t xstate;
    addr_kind_t akind;
    logic [2:0] addr_cnt;
    logic [11:0] col;
    logic [15:0] row;
    logic [11:0] page_units;
    logic status_mode, out_mode;
    logic load_err, xfer_err, pend_err, check_result;
    logic fail_cur, fail_prev;
    logic array_busy, final_busy;
    logic [CNT_W-1:0] array_cnt;
    logic [10:0] xidx;
    logic [9:0] erase_block;
    logic ready6, idle5, dev_busy;
    logic [7:0] status;
    logic go_prog, go_cache, go_erase, go_cbread, valid_cmd;
    logic [1:0] cfg;
    logic [15:0] stuck;
    logic x16;
    logic drive;
    logic [15:0] cache_reg [0:PAGE_DEPTH-1];
    logic [15:0] data_reg [0:PAGE_DEPTH-1];
    logic [10:0] widx;
    logic [15:0] rd_word;
    logic bus_wr_pend;
    logic [7:0] bus_addr;

    // Pins are asynchronous; a level counts once stages two and three agree
    assign pins_raw = {ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_in};
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    sync1[gi] <= PIN_RST[gi];
                    sync2[gi] <= PIN_RST[gi];
                    sync3[gi] <= PIN_RST[gi];
                    filt[gi] <= PIN_RST[gi];
                end
                else
                begin
                    sync1[gi] <= pins_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi])
                        filt[gi] <= sync3[gi];
                end
            end
        end
    endgenerate
    assign {f_ce_n, f_cle, f_ale, f_we_n, f_re_n, f_wp_n, f_io} = filt;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            we_d <= 1'b1;
            re_d <= 1'b1;
        end
        else
        begin
            we_d <= f_we_n;
            re_d <= f_re_n;
        end
    end

    assign we_rise = f_we_n & ~we_d;
    assign re_rise = f_re_n & ~re_d;
    assign bus_sel = ~f_ce_n & f_re_n;
    assign cmd_wr = we_rise & bus_sel & f_cle & ~f_ale;
    assign addr_wr = we_rise & bus_sel & f_ale & ~f_cle;
    assign data_wr = we_rise & bus_sel & ~f_ale & ~f_cle & (cstate == S_DATA);
    assign cmd = f_io[7:0];
    assign x16 = cfg[CFG_X16];
    assign page_units = x16 ? PAGE_WORDS : PAGE_BYTES;
    assign widx = x16 ? col[10:0] : col[11:1];

    // Status byte built from live engine state
    assign ready6 = (xstate == X_IDLE) & ~final_busy;
    assign idle5 = ~array_busy & (xstate == X_IDLE);
    assign dev_busy = ~ready6;
    assign status = {f_wp_n, ready6, idle5, 3'h0, fail_prev, fail_cur};

    assign valid_cmd = (cmd == CMD_READ) | (cmd == CMD_PROG_SETUP) |
        (cmd == CMD_RAND_IN) | (cmd == CMD_PROG_CONF) |
        (cmd == CMD_CACHE_PROG) | (cmd == CMD_CB_READ) |
        (cmd == CMD_ERASE_SETUP) | (cmd == CMD_ERASE_CONF) |
        (cmd == CMD_STATUS) | (cmd == CMD_RESET);

    // Start strobes act on the very edge that latches the confirm
    assign go_prog = cmd_wr & ~dev_busy & (cstate == S_DATA) &
        (cmd == CMD_PROG_CONF) & f_wp_n;
    assign go_cache = cmd_wr & ~dev_busy & (cstate == S_DATA) &
        (cmd == CMD_CACHE_PROG) & f_wp_n;
    assign go_erase = cmd_wr & ~dev_busy & (cstate == S_ECONF) &
        (cmd == CMD_ERASE_CONF) & f_wp_n;
    assign go_cbread = cmd_wr & ~dev_busy & (cstate == S_RWAIT) &
        (cmd == CMD_CB_READ);

    // Command and address decoder
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cstate <= S_IDLE;
            akind <= AK_PROG;
            addr_cnt <= 3'h0;
            col <= 12'h000;
            row <= 16'h0000;
        end
        else if (cmd_wr && cmd == CMD_RESET)
            cstate <= S_IDLE;
        else if (cmd_wr && !dev_busy)
        begin
            addr_cnt <= 3'h0;
            case (cmd)
                CMD_PROG_SETUP:
                begin
                    cstate <= S_ADDR;
                    akind <= AK_PROG;
                end
                CMD_RAND_IN:
                begin
                    cstate <= S_ADDR;
                    akind <= (cstate == S_DATA) ? AK_RAND : AK_PROG;
                end
                CMD_READ:
                begin
                    cstate <= S_ADDR;
                    akind <= AK_READ;
                end
                CMD_ERASE_SETUP:
                    cstate <= S_EADDR;
                CMD_STATUS:
                    cstate <= cstate;
                default:
                    cstate <= S_IDLE;
            endcase
        end
        else if (addr_wr && cstate == S_ADDR)
        begin
            addr_cnt <= addr_cnt + 3'h1;
            case (addr_cnt)
                3'h0:
                    col[7:0] <= f_io[7:0];
                3'h1:
                begin
                    col[11:8] <= f_io[3:0];
                    if (akind == AK_RAND)
                        cstate <= S_DATA;
                end
                3'h2:
                    row[7:0] <= f_io[7:0];
                default:
                begin
                    row[15:8] <= f_io[7:0];
                    cstate <= (akind == AK_READ) ? S_RWAIT : S_DATA;
                end
            endcase
        end
        else if (addr_wr && cstate == S_EADDR)
        begin
            addr_cnt <= addr_cnt + 3'h1;
            if (addr_cnt == 3'h0)
                row[7:0] <= f_io[7:0];
            else
                row[15:8] <= f_io[7:0];
            if (addr_cnt == ERASE_ADDR_LAST)
                cstate <= S_ECONF;
        end
        else if (data_wr && col < page_units)
            col <= col + 12'h001;
        else if (re_rise && out_mode && !status_mode && !dev_busy &&
            col < page_units)
            col <= col + 12'h001;
    end

    chk_col_advance:
    assert property (@(posedge hclk) disable iff (!hresetn)
        data_wr && !cmd_wr && !addr_wr && col < page_units
        |=> col == $past(col) + 12'h001)
    else $error("load pointer did not advance");

    chk_random_col:
    assert property (@(posedge hclk) disable iff (!hresetn)
        addr_wr && !cmd_wr && cstate == S_ADDR && akind == AK_RAND &&
        addr_cnt == 3'h1 |=> cstate == S_DATA && col[7:0] == $past(col[7:0]))
    else $error("random input did not return to loading");

    chk_busy_reject:
    assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && dev_busy && cmd == CMD_PROG_SETUP
        |=> cstate == $past(cstate))
    else $error("command taken while busy");

    // Status and data output modes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            status_mode <= 1'b0;
            out_mode <= 1'b0;
        end
        else if (cmd_wr && cmd == CMD_STATUS)
            status_mode <= 1'b1;
        else if (cmd_wr && valid_cmd && (!dev_busy || cmd == CMD_RESET))
        begin
            status_mode <= 1'b0;
            out_mode <= go_cbread;
        end
    end

    chk_status_mode:
    assert property (@(posedge hclk) disable iff (!hresetn)
        status_mode && !cmd_wr |=> status_mode)
    else $error("status mode left without a command");

    // Load path; a loaded zero over a stuck-at-one bit fails verify
    always_ff @(posedge hclk)
    begin
        if (data_wr && col < page_units)
        begin
            if (x16)
                cache_reg[widx] <= f_io;
            else if (col[0])
                cache_reg[widx][15:8] <= f_io[7:0];
            else
                cache_reg[widx][7:0] <= f_io[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            load_err <= 1'b0;
        else if (cmd_wr && !dev_busy && cmd == CMD_PROG_SETUP)
            load_err <= 1'b0;
        else if (data_wr && col < page_units)
            load_err <= load_err | (x16 ? |(stuck & ~f_io) :
                |(stuck[7:0] & ~f_io[7:0]));
    end

    always_ff @(posedge hclk)
    begin
        if (xstate == X_COPY)
            data_reg[xidx] <= cache_reg[xidx];
    end

    // Program engine: cache transfer feeding the array timer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            xstate <= X_IDLE;
            xidx <= 11'h000;
            final_busy <= 1'b0;
            array_busy <= 1'b0;
            array_cnt <= '0;
            xfer_err <= 1'b0;
            pend_err <= 1'b0;
            check_result <= 1'b0;
            fail_cur <= 1'b0;
            fail_prev <= 1'b0;
            erase_block <= 10'h000;
        end
        else if (cmd_wr && cmd == CMD_RESET)
        begin
            xstate <= X_IDLE;
            final_busy <= 1'b0;
            array_busy <= 1'b0;
            fail_cur <= 1'b0;
            fail_prev <= 1'b0;
        end
        else
        begin
            if (go_prog || go_cache)
            begin
                xstate <= X_WAIT;
                final_busy <= go_prog;
                xfer_err <= load_err;
            end
            else if (go_erase)
            begin
                array_busy <= 1'b1;
                array_cnt <= CNT_W'(erase_cycles - 1);
                final_busy <= 1'b1;
                pend_err <= cfg[CFG_ERASE_FAIL];
                check_result <= 1'b1;
                erase_block <= row[15:BLOCK_LSB];
            end
            else if (go_cbread)
            begin
                array_busy <= 1'b1;
                array_cnt <= CNT_W'(read_cycles - 1);
                final_busy <= 1'b1;
                check_result <= 1'b0;
            end
            else
            begin
                case (xstate)
                    X_IDLE:
                        xidx <= 11'h000;
                    X_WAIT:
                        if (!array_busy)
                            xstate <= X_COPY;
                    X_COPY:
                    begin
                        xidx <= xidx + 11'h001;
                        if (xidx == XFER_LAST)
                        begin
                            xstate <= X_IDLE;
                            array_busy <= 1'b1;
                            array_cnt <= CNT_W'(prog_cycles - 1);
                            pend_err <= xfer_err;
                            check_result <= 1'b1;
                            fail_prev <= fail_cur;
                        end
                    end
                    default:
                        xstate <= X_IDLE;
                endcase
                if (array_busy && !(xstate == X_COPY && xidx == XFER_LAST))
                begin
                    if (array_cnt == '0)
                    begin
                        array_busy <= 1'b0;
                        if (check_result)
                            fail_cur <= pend_err;
                        if (xstate == X_IDLE)
                            final_busy <= 1'b0;
                    end
                    else
                        array_cnt <= array_cnt - 1'b1;
                end
            end
        end
    end

    chk_wp_blocks:
    assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && cstate == S_ECONF && cmd == CMD_ERASE_CONF && !f_wp_n &&
        !array_busy |=> !array_busy)
    else $error("erase started under write protect");

    chk_erase_runs:
    assert property (@(posedge hclk) disable iff (!hresetn)
        go_erase && !(cmd_wr && cmd == CMD_RESET)
        |=> array_busy && !ready6 [*8])
    else $error("erase did not start at confirm edge");

    chk_erase_block:
    assert property (@(posedge hclk) disable iff (!hresetn)
        go_erase |=> erase_block == $past(row[15:6]))
    else $error("erase block address wrong");

    chk_xfer_holds:
    assert property (@(posedge hclk) disable iff (!hresetn)
        xstate == X_WAIT && array_busy && !cmd_wr |=> xstate == X_WAIT)
    else $error("cache transfer overtook programming");

    chk_prev_result:
    assert property (@(posedge hclk) disable iff (!hresetn)
        xstate == X_COPY && xidx == XFER_LAST && !cmd_wr
        |=> fail_prev == $past(fail_cur) && array_busy)
    else $error("previous page result not shifted");

    chk_reset_abort:
    assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_wr && cmd == CMD_RESET
        |=> !array_busy && xstate == X_IDLE && cstate == S_IDLE && !fail_cur)
    else $error("reset command did not abort");

    // Pins: status follows the engine without further strobes
    assign drive = ~f_ce_n & ~f_re_n & f_we_n & (status_mode | out_mode);
    assign rd_word = cache_reg[widx];
    assign ready_busy_line_out = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            io_out <= 16'h0000;
            io_oe_n <= 1'b1;
            ready_busy_line_oe_n <= 1'b1;
        end
        else
        begin
            io_oe_n <= ~drive;
            if (status_mode)
                io_out <= {8'h00, status};
            else if (x16)
                io_out <= rd_word;
            else
                io_out <= {8'h00, col[0] ? rd_word[15:8] : rd_word[7:0]};
            ready_busy_line_oe_n <= ready6;
        end
    end

    chk_status_drive:
    assert property (@(posedge hclk) disable iff (!hresetn)
        status_mode && drive |=> !io_oe_n && io_out[7:0] == $past(status))
    else $error("status byte not driven");

    chk_rb_busy:
    assert property (@(posedge hclk) disable iff (!hresetn)
        go_prog |-> ##2 !ready_busy_line_oe_n)
    else $error("ready/busy not pulled low");

    // AHB-Lite slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_wr_pend <= 1'b0;
            bus_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            bus_wr_pend <= hsel & hready & htrans[1] & hwrite;
            bus_addr <= haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite)
            begin
                case (haddr[7:0])
                    REG_CFG:
                        hrdata <= {30'h0, cfg};
                    REG_STUCK:
                        hrdata <= {16'h0, stuck};
                    REG_STATE:
                        hrdata <= {21'h0, out_mode, status_mode, array_busy,
                            status};
                    REG_ADDR:
                        hrdata <= {4'h0, col, row};
                    REG_BLOCK:
                        hrdata <= {22'h0, erase_block};
                    default:
                        hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg <= CFG_RESET;
            stuck <= STUCK_RESET;
        end
        else if (bus_wr_pend)
        begin
            if (bus_addr == REG_CFG)
                cfg <= hwdata[1:0];
            if (bus_addr == REG_STUCK)
                stuck <= hwdata[15:0];
        end
    end
endmodule

// File: verif/nand_host_model.sv
// Behavioural NAND host controller driving the device pins
`timescale 1ns/1ps
module nand_host_model (
    input wire logic hclk,
    input wire logic [15:0] io_out,
    input wire logic io_oe_n,
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic [15:0] io_in,
    output logic got,
    output logic [31:0] got_val
);
    // Idle levels: deselected, no strobe
    initial
    begin
        ce_n = 1'h1;
        cle = 1'h0;
        ale = 1'h0;
        we_n = 1'h1;
        read_strobe_n = 1'h1;
        io_in = 16'h0;
        got = 1'h0;
        got_val = 32'h0;
    end
    // Six-clock phases clear the device's pin filter
    task automatic ph(input logic c, input logic a, input logic [15:0] d);
        ce_n <= 1'h0;
        cle <= c;
        ale <= a;
        io_in <= d;
        we_n <= 1'h0;
        repeat (6) @(posedge hclk);
        we_n <= 1'h1;
        repeat (6) @(posedge hclk);
        io_in <= ~d; // Released bus must not keep a stale value
        @(posedge hclk);
    endtask
    task automatic cmd(input logic [7:0] c);
        ph(1'h1, 1'h0, {8'h0, c});
    endtask
    // One fixed page address keeps cache pages in one block
    task automatic adr(input int n);
        repeat (n) ph(1'h0, 1'h1, 16'h1);
    endtask
    task automatic dat(input logic [15:0] d);
        ph(1'h0, 1'h0, d);
    endtask
    task automatic stat(input logic c);
        if (c)
            cmd(8'h70);
        read_strobe_n <= 1'h0;
        repeat (10) @(posedge hclk);
        got_val <= io_oe_n ? 32'hdead : {24'h0, io_out[7:0]};
        got <= 1'h1;
        read_strobe_n <= 1'h1;
        @(posedge hclk);
        got <= 1'h0;
        repeat (5) @(posedge hclk);
    endtask
endmodule

// File: verif/nand_program_erase_sequencer_test.sv
// Self-checking bench for the NAND program/erase sequencer
`timescale 1ns/1ps
module nand_program_erase_sequencer_test;
    import nand_seq_pkg::*;
    logic hclk, hresetn, hsel, hwrite;
    logic wp_n, ag = 1'h0;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, av = 32'h0;
    logic [31:0] q[$];
    logic [31:0] hrdata, got_val;
    logic [IO_W-1:0] io_in, io_out;
    logic hreadyout, hresp, io_oe_n, rb_out, rb_oe_n, rb_line, got;
    logic ce_n, cle, ale, we_n, read_strobe_n;
    int n_fail = 0;
    int compares = 0;
    int cnt;
    assign rb_line = rb_oe_n ? 1'h1 : rb_out; // Pull-up on the wire
    always #2.5 hclk = ~hclk;
    nand_program_erase_sequencer #(.prog_cycles(200), .erase_cycles(300),
        .read_cycles(10)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_in(io_in),
        .io_out(io_out), .io_oe_n(io_oe_n), .ready_busy_line_in(rb_line),
        .ready_busy_line_out(rb_out), .ready_busy_line_oe_n(rb_oe_n));
    nand_host_model h (.hclk(hclk), .io_out(io_out), .io_oe_n(io_oe_n),
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .io_in(io_in), .got(got),
        .got_val(got_val));
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    always @(posedge hclk)
        if (got === 1'h1 || ag)
            ck(got === 1'h1 ? got_val : av, q.pop_front());
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        ck({31'h0, hresp}, 32'h0);
        av <= hrdata;
        ag <= !w;
        @(posedge hclk);
        ag <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        ahb(1'h0, a, 32'h0);
    endtask
    task automatic st(input logic [7:0] e, input logic c);
        q.push_back({24'h0, e});
        h.stat(c);
    endtask
    task automatic rb(input logic e);
        repeat (4) @(posedge hclk);
        ck({31'h0, rb_line}, {31'h0, e});
    endtask
    task automatic wrb();
        cnt = 0;
        while (rb_line !== 1'h1 && cnt < 3000)
        begin
            @(posedge hclk);
            cnt++;
        end
        ck({31'h0, rb_line}, 32'h1);
    endtask
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge hclk);
        n_fail++;
        stop_test();
    end
    initial
    begin
        hclk = 1'h0;
        hresetn = 1'h0;
        hsel = 1'h0;
        hwrite = 1'h0;
        wp_n = 1'h1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        cnt = $urandom(35011);
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (6) @(posedge hclk);
        rb(1'h1);
        rd(REG_CFG, 32'h0);
        rd(8'h40, 32'h0);
        ahb(1'h1, REG_STUCK, 32'h1);
        rd(REG_STUCK, 32'h1);
        $display("test registers done");
        h.cmd(CMD_PROG_SETUP);
        h.adr(4);
        repeat (3) h.dat(16'($urandom) | 16'h1);
        h.cmd(CMD_RAND_IN);
        h.adr(2);
        h.dat(16'($urandom) | 16'h1);
        h.cmd(CMD_PROG_CONF);
        rb(1'h0);
        wrb();
        st(8'he0, 1'h1);
        h.cmd(CMD_READ);
        h.adr(4);
        h.cmd(CMD_CB_READ);
        wrb();
        h.cmd(CMD_RAND_IN);
        h.adr(4);
        h.dat(16'($urandom) | 16'h1);
        h.cmd(CMD_PROG_CONF);
        wrb();
        st(8'he0, 1'h1);
        $display("test program and copy-back done");
        // Word mode: a stuck bit in the high byte only fails in x16
        ahb(1'h1, REG_CFG, 32'h1);
        ahb(1'h1, REG_STUCK, 32'h100);
        h.cmd(CMD_PROG_SETUP);
        h.adr(4);
        h.dat(16'h0);
        h.cmd(CMD_PROG_CONF);
        wrb();
        st(8'he1, 1'h1);
        h.cmd(CMD_RESET);
        st(8'he0, 1'h1);
        ahb(1'h1, REG_CFG, 32'h0);
        $display("test verify fail done");
        h.cmd(CMD_PROG_SETUP);
        h.adr(4);
        h.dat(16'($urandom) | 16'h1);
        h.cmd(CMD_CACHE_PROG);
        wrb();
        ck({31'h0, cnt > 1000}, 32'h1);
        st(8'hc0, 1'h1);
        h.cmd(CMD_PROG_SETUP);
        h.adr(4);
        h.dat(16'($urandom) | 16'h1);
        h.cmd(CMD_CACHE_PROG);
        wrb();
        ck({31'h0, cnt > 1100}, 32'h1);
        st(8'hc0, 1'h1);
        repeat (250) @(posedge hclk);
        st(8'he0, 1'h1);
        $display("test cache program done");
        ahb(1'h1, REG_CFG, 32'h2);
        h.cmd(CMD_ERASE_SETUP);
        h.adr(2);
        h.cmd(CMD_ERASE_CONF);
        rb(1'h0);
        h.cmd(CMD_PROG_SETUP);
        st(8'h80, 1'h1);
        wrb();
        st(8'he1, 1'h0);
        rd(REG_BLOCK, 32'h4);
        wp_n <= 1'h0;
        h.cmd(CMD_ERASE_SETUP);
        h.adr(2);
        h.cmd(CMD_ERASE_CONF);
        rb(1'h1);
        st(8'h61, 1'h1);
        wp_n <= 1'h1;
        ahb(1'h1, REG_CFG, 32'h0);
        h.cmd(CMD_ERASE_SETUP);
        h.adr(2);
        h.cmd(CMD_ERASE_CONF);
        h.cmd(CMD_RESET);
        wrb();
        ck({31'h0, cnt < 40}, 32'h1);
        st(8'he0, 1'h1);
        $display("test erase and abort done");
        stop_test();
    end
endmodule
